/* File: shared/qos_pkg.sv */
// Package: constants and types for the Layer 2 strict priority egress scheduler
package qos_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_PORTS  = 4;
  localparam int NUM_QUEUES = 4;
  localparam int PORT_W     = 2;
  localparam int PRIO_W     = 2;
  localparam int PCP_W      = 3;
  localparam int BYTE_W     = 8;
  localparam int LEN_W      = 16;
  localparam int DROP_W     = 16;
  // Shared pool limit: 1 Mbit, i.e. 128 KB of occupancy for all queues together
  localparam int POOL_BYTES = 131072;

  // ----------------------------------------------------------------
  // Rates in kbps, system clock in kHz
  // ----------------------------------------------------------------
  localparam int RATE_W         = 15;
  localparam int MAX_RATE_KBPS  = 25000;
  localparam int LOW_BAND_KBPS  = 1000;
  localparam int STEP_LOW_KBPS  = 64;
  localparam int STEP_HIGH_KBPS = 1000;
  localparam int CLK_KHZ        = 10000;
  // One byte leaves once the per-cycle rate sum reaches this credit
  localparam int CREDIT_PER_BYTE = BYTE_W * CLK_KHZ;
  localparam int CRED_W          = 18;

  // ----------------------------------------------------------------
  // Pause thresholds, as fractions of the pool (shift amounts)
  // ----------------------------------------------------------------
  localparam int XOFF_FREE_SHIFT = 2;
  localparam int XON_USED_SHIFT  = 1;

  typedef enum logic [1:0] {
    QOS_MODE_PORT,
    QOS_MODE_VLAN,
    QOS_MODE_PORT_VLAN
  } qos_mode_t;

endpackage

/* File: verif/qos_modem_model.sv */
// Modem transmit side model: takes output bytes, can stall, logs the first byte of each frame
module qos_modem_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       stall,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  int         beats = 0;
  logic [7:0] heads[$];
  logic       mid_q;

  // A stall holds ready low, so the two-entry buffer must keep its words
  assign out_ready = ~stall;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      mid_q <= 1'b0;
    end else if (out_valid && out_ready) begin
      beats++;
      if (!mid_q)
        heads.push_back(out_data);
      mid_q <= ~out_last;
    end
  end
endmodule // qos_modem_model

/* File: verif/tb.sv */
// Self-checking testbench for the strict priority egress scheduler
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import qos_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Small pool keeps fill, pause and drop cases short
  localparam int POOL     = 64;
  localparam int LIMIT    = 20000;
  localparam int RATES[8] = '{180, 64, 999, 1000, 1001, 2500, 30000, 25000};
  localparam int QRATE[8] = '{192, 64, 1024, 1000, 2000, 3000, 25000, 25000};

  logic                  clk_sys = 1'b0;
  logic                  rstn;
  qos_mode_t             mode;
  logic [7:0]            port_prio;
  logic [3:0]            pause_en;
  logic [14:0]           modem_rate_kbps;
  logic                  in_valid, in_first, in_last, in_tagged, stall;
  logic [7:0]            in_data, out_data;
  logic [1:0]            in_port;
  logic [15:0]           in_len;
  logic [2:0]            in_pcp;
  logic                  out_valid, out_ready, out_last;
  logic [14:0]           qos_rate_kbps;
  logic [3:0]            pause_req;
  logic [63:0]           drop_cnt;
  logic [$clog2(POOL):0] pool_used;
  int                    fail_count = 0;
  int                    total_checks = 0;
  int                    cyc = 0;
  int                    b0, t0;

  always #50 clk_sys = ~clk_sys;

  qos_sched #(.POOL(POOL)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .mode(mode), .port_prio(port_prio),
    .pause_en(pause_en), .modem_rate_kbps(modem_rate_kbps), .in_valid(in_valid),
    .in_data(in_data), .in_first(in_first), .in_last(in_last), .in_port(in_port),
    .in_len(in_len), .in_tagged(in_tagged), .in_pcp(in_pcp), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .qos_rate_kbps(qos_rate_kbps), .pause_req(pause_req), .drop_cnt(drop_cnt),
    .pool_used(pool_used)
  );

  qos_modem_model modem (
    .clk_sys(clk_sys), .rstn(rstn), .stall(stall), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc >= LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // First byte of every frame carries its id in the upper nibble
  task automatic send(input logic [1:0] p, input int len, input logic tg,
                      input logic [2:0] pc, input logic [3:0] id);
    for (int i = 0; i < len; i++) begin
      in_valid  <= 1'b1;
      in_first  <= (i == 0);
      in_last   <= (i == len - 1);
      in_port   <= p;
      in_len    <= 16'(len);
      in_tagged <= tg;
      in_pcp    <= pc;
      in_data   <= {id, 4'(i)};
      @(posedge clk_sys);
    end
  endtask

  // Release the modem and compare frame order; waits for the last frame to end
  task automatic flush(input int n, input logic [31:0] ids);
    in_valid <= 1'b0;
    stall    <= 1'b0;
    // Falling edge: the model's rising-edge updates have settled by then
    for (int k = 0; k < 3000 && (modem.heads.size() < n || modem.mid_q); k++)
      @(negedge clk_sys);
    @(posedge clk_sys);
    check(modem.heads.size(), n);
    for (int k = 0; k < n; k++)
      check(modem.heads[k], {ids[4*(n-1-k)+:4], 4'h0});
    modem.heads.delete();
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; mode = QOS_MODE_PORT; port_prio = 8'he4; pause_en = 4'h0;
    modem_rate_kbps = 15'h0; in_valid = 1'b0; in_first = 1'b0; in_last = 1'b0;
    in_tagged = 1'b0; stall = 1'b0; in_data = 8'h0; in_port = 2'h0;
    in_len = 16'h0; in_pcp = 3'h0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check(pool_used, 0);
    check(pause_req, 0);
    for (int i = 0; i < 8; i++) begin
      modem_rate_kbps <= 15'(RATES[i]);
      repeat (2) @(posedge clk_sys);
      check(qos_rate_kbps, QRATE[i]);
    end
    $display("test rate_table done");

    // Held frames: the first is already granted, the rest wait for its end
    stall <= 1'b1;
    send(2'd0, 4, 1'b0, 3'h0, 4'h1);
    send(2'd1, 4, 1'b0, 3'h0, 4'h2);
    send(2'd3, 4, 1'b0, 3'h0, 4'h3);
    send(2'd2, 4, 1'b0, 3'h0, 4'h4);
    flush(4, 32'h1342);
    port_prio <= 8'h1b;
    stall     <= 1'b1;
    send(2'd2, 4, 1'b0, 3'h0, 4'h5);
    send(2'd3, 4, 1'b1, 3'h7, 4'h6);
    send(2'd0, 4, 1'b0, 3'h0, 4'h7);
    send(2'd1, 4, 1'b0, 3'h0, 4'h8);
    flush(4, 32'h5786);
    $display("test port_mode done");

    mode      <= QOS_MODE_VLAN;
    port_prio <= 8'he4;
    stall     <= 1'b1;
    send(2'd0, 4, 1'b1, 3'h0, 4'h1);
    send(2'd1, 4, 1'b1, 3'h2, 4'h2);
    send(2'd0, 4, 1'b1, 3'h7, 4'h3);
    send(2'd1, 4, 1'b1, 3'h4, 4'h4);
    send(2'd2, 4, 1'b1, 3'h6, 4'h5);
    send(2'd3, 4, 1'b1, 3'h1, 4'h6);
    send(2'd0, 4, 1'b1, 3'h5, 4'h7);
    send(2'd2, 4, 1'b1, 3'h3, 4'h8);
    flush(8, 32'h13547286);
    $display("test vlan_mode done");

    mode  <= QOS_MODE_PORT_VLAN;
    stall <= 1'b1;
    send(2'd0, 4, 1'b0, 3'h0, 4'h1);
    send(2'd0, 4, 1'b1, 3'h7, 4'h2);
    send(2'd3, 4, 1'b0, 3'h0, 4'h3);
    send(2'd3, 4, 1'b1, 3'h0, 4'h4);
    send(2'd1, 4, 1'b0, 3'h0, 4'h5);
    flush(5, 32'h12354);
    $display("test port_vlan_mode done");

    // Two frames fill the pool past the pause level; a third cannot fit
    mode     <= QOS_MODE_PORT;
    pause_en <= 4'b0101;
    stall    <= 1'b1;
    send(2'd1, 30, 1'b0, 3'h0, 4'h1);
    send(2'd2, 30, 1'b0, 3'h0, 4'h2);
    send(2'd2, 30, 1'b0, 3'h0, 4'h3);
    in_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(pause_req, 4'b0101);
    check(drop_cnt[47:32], 1);
    check(drop_cnt[31:0], 0);
    check(drop_cnt[63:48], 0);
    flush(2, 32'h12);
    check(pool_used, 0);
    check(pause_req, 0);
    $display("test drop_pause done");

    // Scheduling runs at 3000 kbps, the modem clips it to 2500 kbps
    modem_rate_kbps <= 15'd2500;
    b0 = modem.beats;
    send(2'd0, 30, 1'b0, 3'h0, 4'h9);
    in_valid <= 1'b0;
    for (int k = 0; k < 2000 && modem.beats == b0; k++)
      @(negedge clk_sys);
    t0 = cyc;
    for (int k = 0; k < 3000 && modem.beats < b0 + 30; k++)
      @(negedge clk_sys);
    check(modem.beats - b0, 30);
    check((cyc - t0) >= 894 && (cyc - t0) <= 940, 1);
    $display("test rate_clip done");
    tally_and_finish();
  end
endmodule // tb

/* File: verilog/qos_sched.sv */
// Layer 2 QoS strict priority egress scheduler with rate quantiser and modem limiter
//
// Behaviour
// - Each queue has its own memory; one 128 KB occupancy count covers all queues
// - Four queues, four priorities, one shared pool
// - Strict priority, higher number wins, starvation allowed
// - Modes: port, VLAN, port plus VLAN
// - Modem rate set in 1 kbps units
// - QoS rate steps 64k below 1M, else 1M
// - Odd modem rate rounds QoS rate up
// - Schedule at QoS rate, clip to modem rate
// - Aligned modem rate up to 25000 kbps gives equal QoS rate
// - Pause frame flow control with LAN stations
// - Pause enable separate for each port
// - Port mode: per-port priority 1 to 4
// - Port mode: every frame uses port priority
// - No room: drop frame, count per port
// - VLAN priority pairs map onto four queues
// - Double tag: outer tag priority only
// - VLAN mode ignores ingress port
module qos_sched #(
  parameter int POOL = qos_pkg::POOL_BYTES
) (
  input  wire logic                                       clk_sys,
  input  wire logic                                       rstn,
  input  wire qos_pkg::qos_mode_t                         mode,
  input  wire logic [qos_pkg::NUM_PORTS*qos_pkg::PRIO_W-1:0] port_prio,
  input  wire logic [qos_pkg::NUM_PORTS-1:0]              pause_en,
  input  wire logic [qos_pkg::RATE_W-1:0]                 modem_rate_kbps,
  input  wire logic                                       in_valid,
  input  wire logic [qos_pkg::BYTE_W-1:0]                 in_data,
  input  wire logic                                       in_first,
  input  wire logic                                       in_last,
  input  wire logic [qos_pkg::PORT_W-1:0]                 in_port,
  input  wire logic [qos_pkg::LEN_W-1:0]                  in_len,
  input  wire logic                                       in_tagged,
  input  wire logic [qos_pkg::PCP_W-1:0]                  in_pcp,
  output logic                                            out_valid,
  input  wire logic                                       out_ready,
  output logic [qos_pkg::BYTE_W-1:0]                      out_data,
  output logic                                            out_last,
  output logic [qos_pkg::RATE_W-1:0]                      qos_rate_kbps,
  output logic [qos_pkg::NUM_PORTS-1:0]                   pause_req,
  output logic [qos_pkg::NUM_PORTS*qos_pkg::DROP_W-1:0]   drop_cnt,
  output logic [$clog2(POOL):0]                           pool_used
);
  import qos_pkg::*;

  localparam int AW = $clog2(POOL);
  localparam int UW = AW + 1;
  localparam logic [UW-1:0] POOL_U = UW'(POOL);
  localparam logic [UW-1:0] XOFF_U = UW'(POOL - (POOL >> XOFF_FREE_SHIFT));
  localparam logic [UW-1:0] XON_U  = UW'(POOL >> XON_USED_SHIFT);
  localparam logic [CRED_W-1:0] CPB = CRED_W'(CREDIT_PER_BYTE);

  if (POOL < 4 || (1 << AW) != POOL) begin : g_chk
    $error("qos_sched: pool size must be a power of two, at least 4");
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // Rate quantiser
  // ----------------------------------------------------------------
  logic [RATE_W-1:0] rate_clamped;
  logic [RATE_W-1:0] qos_rate_d;
  logic [RATE_W-1:0] qos_rate_q;

  always_comb begin
    logic [RATE_W:0] up;
    up = '0;
    rate_clamped = (modem_rate_kbps > RATE_W'(MAX_RATE_KBPS)) ?
                   RATE_W'(MAX_RATE_KBPS) : modem_rate_kbps;
    // step by band, round up, aligned passes through
    if (rate_clamped < RATE_W'(LOW_BAND_KBPS)) begin
      up = {1'b0, rate_clamped} + (RATE_W+1)'(STEP_LOW_KBPS - 1);
      qos_rate_d = RATE_W'((up / (RATE_W+1)'(STEP_LOW_KBPS)) * (RATE_W+1)'(STEP_LOW_KBPS));
    end else begin
      up = {1'b0, rate_clamped} + (RATE_W+1)'(STEP_HIGH_KBPS - 1);
      qos_rate_d = RATE_W'((up / (RATE_W+1)'(STEP_HIGH_KBPS)) * (RATE_W+1)'(STEP_HIGH_KBPS));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      qos_rate_q <= '0;
    end else begin
      qos_rate_q <= qos_rate_d;
    end
  end
  assign qos_rate_kbps = qos_rate_q;

  // ----------------------------------------------------------------
  // Classifier and ingress
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IN_IDLE, IN_STORE, IN_DROP} qos_in_t;
  qos_in_t          in_st_q;
  qos_in_t          in_st_d;
  logic [PRIO_W-1:0] cls_q;
  logic [PRIO_W-1:0] cur_q;
  logic [PRIO_W-1:0] cur_d;
  logic              wr_en;
  logic [PRIO_W-1:0] wr_q;
  logic              drop_evt;
  logic              admit;
  logic [UW-1:0]     used_q;
  logic [UW-1:0]     used_d;
  logic              rd_en;
  logic              rd_last;

  always_comb begin
    logic [PRIO_W-1:0] by_port;
    // two-bit field per port, 0 means priority 1, 3 means priority 4
    by_port = port_prio[in_port*PRIO_W +: PRIO_W];
    // 7,6 to 4; 5,4 to 3; 3,2 to 2; 1,0 to 1.
    // in_pcp carries the outer tag's priority only
    unique case (mode)
      // no port term in VLAN mode
      QOS_MODE_VLAN:      cls_q = in_pcp[PCP_W-1:1];
      QOS_MODE_PORT_VLAN: cls_q = in_tagged ? in_pcp[PCP_W-1:1] : by_port;
      // port priority, whatever the frame holds
      QOS_MODE_PORT:      cls_q = by_port;
      default:            cls_q = by_port;
    endcase
  end

  // admit only if the whole frame fits in the pool
  // Sum taken at 32 bits so neither operand can wrap for any pool size
  assign admit = (32'(used_q) + 32'(in_len)) <= 32'(POOL);

  always_comb begin
    in_st_d  = in_st_q;
    cur_d    = cur_q;
    wr_en    = 1'b0;
    wr_q     = cur_q;
    drop_evt = 1'b0;
    unique case (in_st_q)
      IN_IDLE: begin
        if (in_valid && in_first) begin
          if (admit) begin
            wr_en = 1'b1;
            wr_q  = cls_q;
            cur_d = cls_q;
            in_st_d = in_last ? IN_IDLE : IN_STORE;
          end else begin
            drop_evt = 1'b1;
            in_st_d  = in_last ? IN_IDLE : IN_DROP;
          end
        end
      end
      IN_STORE: begin
        if (in_valid) begin
          wr_en = 1'b1;
          if (in_last) begin
            in_st_d = IN_IDLE;
          end
        end
      end
      IN_DROP: begin
        if (in_valid && in_last) begin
          in_st_d = IN_IDLE;
        end
      end
    endcase
  end

  // one occupancy count for the whole pool
  assign used_d = used_q + {{(UW-1){1'b0}}, wr_en} - {{(UW-1){1'b0}}, rd_en};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      in_st_q <= IN_IDLE;
      cur_q   <= '0;
      used_q  <= '0;
    end else begin
      in_st_q <= in_st_d;
      cur_q   <= cur_d;
      used_q  <= used_d;
    end
  end
  assign pool_used = used_q;

  // ----------------------------------------------------------------
  // Drop counters, one per ingress port
  // ----------------------------------------------------------------
  logic [DROP_W-1:0] drop_q [NUM_PORTS];
  logic [DROP_W-1:0] drop_d [NUM_PORTS];

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_drop
    always_comb begin
      drop_d[p] = drop_q[p];
      if (drop_evt && in_port == PORT_W'(p)) begin
        drop_d[p] = drop_q[p] + DROP_W'(1);
      end
    end
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        drop_q[p] <= '0;
      end else begin
        drop_q[p] <= drop_d[p];
      end
    end
    assign drop_cnt[p*DROP_W +: DROP_W] = drop_q[p];
  end

  // ----------------------------------------------------------------
  // Queues: storage per queue, accounting shared
  // ----------------------------------------------------------------
  // Each queue may grow to the whole pool, so admission against the
  // shared count is the only limit; costs storage, keeps sharing exact.
  logic [BYTE_W:0]   mem_q [NUM_QUEUES][POOL];
  logic [AW-1:0]     wptr_q [NUM_QUEUES];
  logic [AW-1:0]     wptr_d [NUM_QUEUES];
  logic [AW-1:0]     rptr_q [NUM_QUEUES];
  logic [AW-1:0]     rptr_d [NUM_QUEUES];
  logic [UW-1:0]     frm_q  [NUM_QUEUES];
  logic [UW-1:0]     frm_d  [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] avail;
  logic [PRIO_W-1:0] sel_q;
  logic [PRIO_W-1:0] sel_d;

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_q][wptr_q[wr_q]] <= {in_last, in_data};
    end
  end

  // four queues over the single pool
  for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
    always_comb begin
      logic wr_here;
      logic rd_here;
      wr_here  = wr_en && wr_q == PRIO_W'(q);
      rd_here  = rd_en && sel_q == PRIO_W'(q);
      wptr_d[q] = wptr_q[q] + AW'(wr_here);
      rptr_d[q] = rptr_q[q] + AW'(rd_here);
      frm_d[q]  = frm_q[q] + UW'(wr_here && in_last) - UW'(rd_here && rd_last);
    end
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        wptr_q[q] <= '0;
        rptr_q[q] <= '0;
        frm_q[q]  <= '0;
      end else begin
        wptr_q[q] <= wptr_d[q];
        rptr_q[q] <= rptr_d[q];
        frm_q[q]  <= frm_d[q];
      end
    end
    assign avail[q] = (frm_q[q] != '0);
  end

  // ----------------------------------------------------------------
  // Strict priority scheduler at the QoS rate
  // ----------------------------------------------------------------
  logic              busy_q;
  logic              busy_d;
  logic              grant;
  logic [PRIO_W-1:0] pick;
  logic [CRED_W-1:0] qacc_q;
  logic [CRED_W-1:0] qacc_d;
  logic              sk_in_ready;
  logic [BYTE_W:0]   rd_word;
  logic              sk_out_valid;
  logic              sk_out_ready;
  logic [BYTE_W:0]   sk_out_data;
  logic [CRED_W-1:0] macc_q;
  logic [CRED_W-1:0] macc_d;
  logic              mdm_ok;

  always_comb begin
    // highest numbered queue holding a whole frame wins
    pick = '0;
    for (int i = 0; i < NUM_QUEUES; i++) begin
      if (avail[i]) begin
        pick = PRIO_W'(i);
      end
    end
  end

  assign rd_word = mem_q[sel_q][rptr_q[sel_q]];
  assign rd_last = rd_word[BYTE_W];
  assign rd_en   = busy_q && (qacc_q >= CPB) && sk_in_ready;
  // a new pick only when no frame is in flight
  assign grant   = !busy_q && (avail != '0);

  always_comb begin
    busy_d = busy_q;
    sel_d  = sel_q;
    qacc_d = qacc_q + CRED_W'(qos_rate_q);
    if (grant) begin
      busy_d = 1'b1;
      sel_d  = pick;
    end else if (rd_en && rd_last) begin
      busy_d = 1'b0;
    end
    if (rd_en) begin
      qacc_d = qacc_d - CPB;
    end
    // Cap idle credit so a long gap does not turn into a burst
    if (qacc_d > (CPB << 1)) begin
      qacc_d = CPB << 1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      sel_q  <= '0;
      qacc_q <= '0;
    end else begin
      busy_q <= busy_d;
      sel_q  <= sel_d;
      qacc_q <= qacc_d;
    end
  end

  qos_skid #(
    .W (BYTE_W + 1)
  ) u_skid (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (rd_en),
    .in_ready  (sk_in_ready),
    .in_data   (rd_word),
    .out_valid (sk_out_valid),
    .out_ready (sk_out_ready),
    .out_data  (sk_out_data)
  );

  // ----------------------------------------------------------------
  // Modem rate limiter, blind to priority
  // ----------------------------------------------------------------
  assign mdm_ok       = (macc_q >= CPB);
  // clip scheduled stream to modem rate
  assign sk_out_ready = out_ready && mdm_ok;
  assign out_valid    = sk_out_valid && mdm_ok;
  assign out_data     = sk_out_data[BYTE_W-1:0];
  assign out_last     = sk_out_data[BYTE_W];

  always_comb begin
    macc_d = macc_q + CRED_W'(rate_clamped);
    if (out_valid && out_ready) begin
      macc_d = macc_d - CPB;
    end
    if (macc_d > (CPB << 1)) begin
      macc_d = CPB << 1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      macc_q <= '0;
    end else begin
      macc_q <= macc_d;
    end
  end

  // ----------------------------------------------------------------
  // Pause requests towards the LAN MACs
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] pause_q;
  logic [NUM_PORTS-1:0] pause_d;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_pause
    always_comb begin
      pause_d[p] = pause_q[p];
      // XOFF once three quarters full, XON once drained to half
      if (used_q >= XOFF_U) begin
        pause_d[p] = 1'b1;
      end else if (used_q <= XON_U) begin
        pause_d[p] = 1'b0;
      end
      if (!pause_en[p]) begin
        pause_d[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pause_q <= '0;
    end else begin
      pause_q <= pause_d;
    end
  end
  assign pause_req = pause_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pool_bound_a: assert property (used_q <= POOL_U)
    else $error("pool occupancy beyond shared memory");
  drop_count_a: assert property (drop_evt |=> drop_q[$past(in_port)] == $past(drop_q[in_port]) + DROP_W'(1))
    else $error("drop counter did not advance");
  drop_room_a: assert property (in_valid && in_first && in_st_q == IN_IDLE && !admit |-> !wr_en)
    else $error("frame stored without room");
  strict_pick_a: assert property (grant |=> busy_q && ((($past(avail) >> sel_q) >> 1) == '0) && ((($past(avail) >> sel_q) & NUM_QUEUES'(1)) != '0))
    else $error("grant did not take highest queue");
  higher_first_a: assert property (grant |-> ((avail >> pick) >> 1) == '0 && avail[pick])
    else $error("lower queue chosen over waiting higher one");
  vlan_map_a: assert property (wr_en && in_st_q == IN_IDLE && mode == QOS_MODE_VLAN |-> wr_q == in_pcp[PCP_W-1:1])
    else $error("vlan priority mapped to wrong queue");
  port_map_a: assert property (wr_en && in_st_q == IN_IDLE && mode == QOS_MODE_PORT |-> wr_q == port_prio[in_port*PRIO_W +: PRIO_W])
    else $error("port priority not used");
  no_preempt_a: assert property (busy_q && !(rd_en && rd_last) |=> busy_q && $stable(sel_q))
    else $error("frame interrupted by queue change");
  qos_round_a: assert property (##1 qos_rate_q >= $past(rate_clamped) && (qos_rate_q - $past(rate_clamped)) < RATE_W'(STEP_HIGH_KBPS))
    else $error("qos rate not rounded up to next step");
  modem_clip_a: assert property (out_valid |-> macc_q >= CPB)
    else $error("byte sent beyond modem rate");
  pause_gate_a: assert property (##1 (pause_q & ~$past(pause_en)) == '0)
    else $error("pause raised on disabled port");

  frame_drop_c: cover property (drop_evt);
  vlan_store_c: cover property (wr_en && in_st_q == IN_IDLE && mode == QOS_MODE_VLAN);
  frame_out_c:  cover property (out_valid && out_ready && out_last);
  pause_on_c:   cover property (pause_q != '0);

endmodule // qos_sched

/* File: verilog/qos_skid.sv */
// Two-entry buffer with valid and ready on both sides
module qos_skid #(
  parameter int W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import qos_pkg::*;

  logic [W-1:0] slot_q [2];
  logic [W-1:0] slot_d [2];
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;

  if (W < 1) begin : g_chk
    $error("qos_skid: width must be positive");
  end

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = slot_q[0];

  always_comb begin
    logic push;
    logic pop;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    slot_d[0] = slot_q[0];
    slot_d[1] = slot_q[1];
    cnt_d     = cnt_q;
    if (pop) begin
      slot_d[0] = slot_q[1];
    end
    if (push) begin
      if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
        slot_d[0] = in_data;
      end else begin
        slot_d[1] = in_data;
      end
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
    slot_q[0] <= slot_d[0];
    slot_q[1] <= slot_d[1];
  end

endmodule // qos_skid
